/* verilog/mfps_pkg.sv */
// Shared constants and carrier types for the multifunction pin select block
package mfps_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] PIN_CHOICE_OFS = 8'h00; // Pin choice bits, aux device
  localparam logic [7:0] IR_OPTION_OFS = 8'h04; // Infrared option, second uart
  localparam logic [7:0] GLOBAL_ADDR_OFS = 8'h08; // Global address config
  localparam logic [7:0] PAR_IRQ_OFS = 8'h0C; // Parallel irq drive mode
  localparam logic [7:0] PIN_STATUS_OFS = 8'h10; // Read-only pad status

  // Field positions
  localparam int INFRARED_MODE_OUT_BIT = 0; // Infrared mode on density pin
  localparam int DMA3_BIT = 1; // Keyboard bits on dma pins
  localparam int SER_IRQ_BIT = 2; // Parallel irqs instead of serial irq
  localparam int KBC_MODEM_BIT = 3; // Keyboard bits on modem pins
  localparam int IR_RX3_BIT = 4; // Third ir receive on density pin
  localparam int IR_OPT_BIT = 6; // Infrared on uart2 data pins
  localparam int ADDR_QUAL_BIT = 6; // Full 16-bit address qualification
  localparam int PAR_SHARED_BIT = 0; // Enhanced parallel modes enabled

  // Reset values: every pin in its original function
  localparam logic [31:0] PIN_CHOICE_RST = 32'h0000_0000;
  localparam logic [31:0] IR_OPTION_RST = 32'h0000_0000;
  localparam logic [31:0] GLOBAL_ADDR_RST = 32'h0000_0000;
  localparam logic [31:0] PAR_IRQ_RST = 32'h0000_0000;

  // ****************************************
  // Pad and irq indices
  // ****************************************
  localparam int NUM_PADS = 13;
  localparam int PAD_DENSITY = 0;
  localparam int PAD_PCI_CLK = 1;
  localparam int PAD_SER_IRQ = 2;
  localparam int PAD_DACK = 3;
  localparam int PAD_DRQ = 4;
  localparam int PAD_RI = 5;
  localparam int PAD_DCD = 6;
  localparam int PAD_RXD = 7;
  localparam int PAD_TXD = 8;
  localparam int PAD_DSR = 9;
  localparam int PAD_RTS = 10;
  localparam int PAD_CTS = 11;
  localparam int PAD_DTR = 12;

  localparam int NUM_IRQ = 8;
  localparam int IRQ3 = 0;
  localparam int IRQ4 = 1;
  localparam int IRQ5 = 2;
  localparam int IRQ6 = 3;
  localparam int IRQ7 = 4;
  localparam int IRQ10 = 5;
  localparam int IRQ11 = 6;
  localparam int IRQ12 = 7;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 20; // 50 MHz core clock
  localparam int IRQ_PULSE_NS = 100; // Low pulse on a shared irq pin
  localparam int IRQ_PULSE_CYC = (IRQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] IRQ_PULSE_CNT = 4'(IRQ_PULSE_CYC);

  // ****************************************
  // Carrier types
  // ****************************************
  typedef struct packed {
    logic infrared_mode_pin_choice; // Density pin carries infrared_mode_out unless third_ir_rx_choice is set
    logic dma_three_pin_choice; // Dma pins carry keyboard bits
    logic serial_interrupt_choice; // 1: parallel irqs, 0: serial irq
    logic kbc_modem_pin_choice; // Modem pins carry keyboard bits
    logic third_ir_rx_choice; // Density pin is third ir receive
    logic ir_option_choice; // Uart2 data pins are infrared
    logic addr_qual16; // Full 16-bit address qualification
    logic par_irq_shared; // Parallel irqs pulse open drain
  } mfps_cfg_s;

  typedef struct packed {
    logic [NUM_PADS-1:0] o; // Pad output levels
    logic [NUM_PADS-1:0] oe; // Pad output enables
  } mfps_pad_s;

  typedef struct packed {
    logic drive_density_sel_1; // Floppy density select 1
    logic infrared_mode_out; // Infrared mode output
    logic ser_irq_o; // Serial irq drive level
    logic ser_irq_oe; // Serial irq drive enable
    logic dma_ch3_request; // Dma channel 3 request
    logic kbc_port_bit16; // Keyboard controller port bit 16
    logic kbc_port_bit12; // Keyboard controller port bit 12
    logic uart2_transmit_line; // Uart2 transmit data
    logic infrared_transmit; // Infrared transmit data
    logic uart2_req_send_n; // Uart2 request to send
    logic uart2_term_ready_n; // Uart2 terminal ready
  } mfps_fout_s;

  typedef struct packed {
    logic infrared_receive_third; // Third ir receive input
    logic pci_clock_in; // Sampled pci clock level
    logic ser_irq_i; // Serial irq line level
    logic dma_ch3_ack_n; // Dma channel 3 acknowledge
    logic uart2_ring_ind_n; // Uart2 ring indicator
    logic uart2_carrier_det_n; // Uart2 carrier detect
    logic uart2_receive_line; // Uart2 receive data
    logic infrared_receive; // Infrared receive data
    logic uart2_set_ready_n; // Uart2 data set ready
    logic uart2_clear_send_n; // Uart2 clear to send
    logic host_addr_bit_11; // Host address bit 11
    logic host_addr_bit_12; // Host address bit 12
    logic host_addr_bit_13; // Host address bit 13
    logic host_addr_bit_14; // Host address bit 14
    logic host_addr_bit_15; // Host address bit 15
  } mfps_fin_s;

  typedef struct packed {
    logic pready; // Access phase answer
    logic pslverr; // Unmapped or misaligned access, or a write to the read-only status register
    logic [31:0] prdata; // Read data
  } mfps_apb_rsp_s;

endpackage

/* verilog/mfps_irq_drive.sv */
// One parallel interrupt pad driver, push-pull or pulsed open drain
`timescale 1ns/1ns
module mfps_irq_drive (
  input wire logic core_clk, // Core clock
  input wire logic reset, // Synchronous reset, active high
  input wire logic req, // Interrupt request from a function
  input wire logic shared, // Enhanced parallel modes: open drain pulse
  output logic drv_o, // Pad level
  output logic drv_oe // Pad drive enable
);

  typedef struct packed {
    logic req_q; // Previous request for edge detect
    logic [3:0] cnt_q; // Low pulse cycles left
    logic o_q; // Pad level
    logic oe_q; // Pad enable
  } mfps_irq_st_s;

  mfps_irq_st_s st_q;
  mfps_irq_st_s st_d;

  // Next state of the driver
  always_comb begin
    st_d = st_q;
    st_d.req_q = req;
    if (shared) begin
      // Rising request starts a low pulse, then the pad is released
      if (req && !st_q.req_q) begin
        st_d.cnt_q = mfps_pkg::IRQ_PULSE_CNT;
      end else if (st_q.cnt_q != 4'h0) begin
        st_d.cnt_q = st_q.cnt_q - 4'h1;
      end
      st_d.o_q = 1'b0;
      st_d.oe_q = (st_d.cnt_q != 4'h0);
    end else begin
      // Active drive of the request level
      st_d.cnt_q = 4'h0;
      st_d.o_q = req;
      st_d.oe_q = 1'b1;
    end
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign drv_o = st_q.o_q;
  assign drv_oe = st_q.oe_q;

endmodule

/* verilog/mfps_apb_regs.sv */
// APB register slave holding the pin choice configuration
`timescale 1ns/1ns
module mfps_apb_regs (
  input wire logic core_clk, // Core clock
  input wire logic reset, // Synchronous reset, active high
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [31:0] status, // Pad status for readback
  output mfps_pkg::mfps_apb_rsp_s rsp, // Registered APB answer
  output mfps_pkg::mfps_cfg_s cfg // Configuration bits
);

  typedef struct packed {
    mfps_pkg::mfps_apb_rsp_s rsp; // Answer
    mfps_pkg::mfps_cfg_s cfg; // Configuration
  } mfps_reg_st_s;

  mfps_reg_st_s st_q;
  mfps_reg_st_s st_d;

  // Reset image of the configuration
  function automatic mfps_pkg::mfps_cfg_s cfg_reset();
    mfps_pkg::mfps_cfg_s c;
    c.infrared_mode_pin_choice = mfps_pkg::PIN_CHOICE_RST[mfps_pkg::INFRARED_MODE_OUT_BIT];
    c.dma_three_pin_choice = mfps_pkg::PIN_CHOICE_RST[mfps_pkg::DMA3_BIT];
    c.serial_interrupt_choice = mfps_pkg::PIN_CHOICE_RST[mfps_pkg::SER_IRQ_BIT];
    c.kbc_modem_pin_choice = mfps_pkg::PIN_CHOICE_RST[mfps_pkg::KBC_MODEM_BIT];
    c.third_ir_rx_choice = mfps_pkg::PIN_CHOICE_RST[mfps_pkg::IR_RX3_BIT];
    c.ir_option_choice = mfps_pkg::IR_OPTION_RST[mfps_pkg::IR_OPT_BIT];
    c.addr_qual16 = mfps_pkg::GLOBAL_ADDR_RST[mfps_pkg::ADDR_QUAL_BIT];
    c.par_irq_shared = mfps_pkg::PAR_IRQ_RST[mfps_pkg::PAR_SHARED_BIT];
    return c;
  endfunction

  // Decode, one wait state, write at the pready edge
  always_comb begin
    logic hit;
    logic [31:0] rd;
    hit = 1'b1;
    rd = 32'h0000_0000;
    st_d = st_q;
    st_d.rsp.pready = 1'b0;
    st_d.rsp.pslverr = 1'b0;
    // Read image of each register
    case (paddr)
      mfps_pkg::PIN_CHOICE_OFS: begin
        rd[mfps_pkg::INFRARED_MODE_OUT_BIT] = st_q.cfg.infrared_mode_pin_choice;
        rd[mfps_pkg::DMA3_BIT] = st_q.cfg.dma_three_pin_choice;
        rd[mfps_pkg::SER_IRQ_BIT] = st_q.cfg.serial_interrupt_choice;
        rd[mfps_pkg::KBC_MODEM_BIT] = st_q.cfg.kbc_modem_pin_choice;
        rd[mfps_pkg::IR_RX3_BIT] = st_q.cfg.third_ir_rx_choice;
      end
      mfps_pkg::IR_OPTION_OFS: rd[mfps_pkg::IR_OPT_BIT] = st_q.cfg.ir_option_choice;
      mfps_pkg::GLOBAL_ADDR_OFS: rd[mfps_pkg::ADDR_QUAL_BIT] = st_q.cfg.addr_qual16;
      mfps_pkg::PAR_IRQ_OFS: rd[mfps_pkg::PAR_SHARED_BIT] = st_q.cfg.par_irq_shared;
      mfps_pkg::PIN_STATUS_OFS: rd = status;
      default: hit = 1'b0; // Unmapped: error, reads zero
    endcase
    if (psel && penable && !st_q.rsp.pready) begin
      // Answer one cycle into the access phase
      st_d.rsp.pready = 1'b1;
      st_d.rsp.pslverr = !hit || (pwrite && paddr == mfps_pkg::PIN_STATUS_OFS);
      st_d.rsp.prdata = (pwrite || !hit) ? 32'h0000_0000 : rd;
    end
    if (psel && penable && st_q.rsp.pready && pwrite) begin
      // Write takes effect at the completing edge
      case (paddr)
        mfps_pkg::PIN_CHOICE_OFS: begin
          st_d.cfg.infrared_mode_pin_choice = pwdata[mfps_pkg::INFRARED_MODE_OUT_BIT];
          st_d.cfg.dma_three_pin_choice = pwdata[mfps_pkg::DMA3_BIT];
          st_d.cfg.serial_interrupt_choice = pwdata[mfps_pkg::SER_IRQ_BIT];
          st_d.cfg.kbc_modem_pin_choice = pwdata[mfps_pkg::KBC_MODEM_BIT];
          st_d.cfg.third_ir_rx_choice = pwdata[mfps_pkg::IR_RX3_BIT];
        end
        mfps_pkg::IR_OPTION_OFS: st_d.cfg.ir_option_choice = pwdata[mfps_pkg::IR_OPT_BIT];
        mfps_pkg::GLOBAL_ADDR_OFS: st_d.cfg.addr_qual16 = pwdata[mfps_pkg::ADDR_QUAL_BIT];
        mfps_pkg::PAR_IRQ_OFS: st_d.cfg.par_irq_shared = pwdata[mfps_pkg::PAR_SHARED_BIT];
        default: st_d.cfg = st_q.cfg; // Read-only or unmapped
      endcase
    end
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_q.rsp <= '0;
      st_q.cfg <= cfg_reset();
    end else begin
      st_q <= st_d;
    end
  end

  assign rsp = st_q.rsp;
  assign cfg = st_q.cfg;

endmodule

/* verilog/mfps_top.sv */
// Multifunction pin select: routes thirteen shared pads to internal functions
`timescale 1ns/1ns
module mfps_top (
  input wire logic core_clk, // Core clock, 50 MHz
  input wire logic reset, // Synchronous reset, active high
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic [12:0] pad_i, // Pad input levels
  output mfps_pkg::mfps_pad_s pad, // Pad output levels and enables
  input wire logic chip_select_n, // Chip select pad
  input wire logic [7:0] par_irq_req, // Parallel irq requests, irq3..irq12
  input wire mfps_pkg::mfps_fout_s fout, // Outputs of internal functions
  output mfps_pkg::mfps_fin_s fin // Inputs to internal functions
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [12:0] meta_q; // First synchroniser stage
    logic [12:0] sync_q; // Second synchroniser stage
    logic cs_meta_q; // Chip select first stage
    logic cs_sync_q; // Chip select second stage
    mfps_pkg::mfps_pad_s pad_q; // Registered pad drive
    mfps_pkg::mfps_fin_s fin_q; // Registered function inputs
  } mfps_top_st_s;

  mfps_top_st_s st_q;
  mfps_top_st_s st_d;

  mfps_pkg::mfps_cfg_s cfg; // Configuration from the registers
  mfps_pkg::mfps_apb_rsp_s rsp; // APB answer
  logic [7:0] irq_o; // Irq driver levels
  logic [7:0] irq_oe; // Irq driver enables
  logic [31:0] status; // Readback image

  // ****************************************
  // Register slave
  // ****************************************
  mfps_apb_regs mfps_apb_regs_i (
    .core_clk(core_clk),
    .reset(reset),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .status(status),
    .rsp(rsp),
    .cfg(cfg)
  );

  // Status: enables above, synchronised pad levels below
  assign status = {3'h0, st_q.pad_q.oe, 3'h0, st_q.sync_q};

  // ****************************************
  // Parallel irq drivers
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < mfps_pkg::NUM_IRQ; gi = gi + 1) begin : g_irq
      mfps_irq_drive mfps_irq_drive_i (
        .core_clk(core_clk),
        .reset(reset),
        .req(par_irq_req[gi]),
        .shared(cfg.par_irq_shared),
        .drv_o(irq_o[gi]),
        .drv_oe(irq_oe[gi])
      );
    end
  endgenerate

  // ****************************************
  // Pad routing
  // ****************************************
  // One assignment per pad path, so no pad has two drivers
  always_comb begin
    logic [12:0] s;
    logic par_irq;
    logic addr_mode;
    s = st_q.sync_q;
    par_irq = cfg.serial_interrupt_choice;
    addr_mode = cfg.addr_qual16;
    st_d = st_q;
    // Synchronisers: first stage read only by the second
    st_d.meta_q = pad_i;
    st_d.sync_q = st_q.meta_q;
    st_d.cs_meta_q = chip_select_n;
    st_d.cs_sync_q = st_q.cs_meta_q;
    // Default: nothing driven, inputs inactive
    st_d.pad_q.o = 13'h0000;
    st_d.pad_q.oe = 13'h0000;
    st_d.fin_q = '0;
    st_d.fin_q.pci_clock_in = 1'b0;
    st_d.fin_q.ser_irq_i = 1'b0;
    st_d.fin_q.dma_ch3_ack_n = 1'b1;
    st_d.fin_q.uart2_ring_ind_n = 1'b1;
    st_d.fin_q.uart2_carrier_det_n = 1'b1;
    st_d.fin_q.uart2_receive_line = 1'b1;
    st_d.fin_q.infrared_receive = 1'b0;
    st_d.fin_q.uart2_set_ready_n = 1'b1;
    st_d.fin_q.uart2_clear_send_n = 1'b1;

    // Density pin; third ir receive wins over infrared_mode_out
    if (cfg.third_ir_rx_choice) begin
      st_d.fin_q.infrared_receive_third = s[mfps_pkg::PAD_DENSITY];
    end else if (cfg.infrared_mode_pin_choice) begin
      st_d.pad_q.o[mfps_pkg::PAD_DENSITY] = fout.infrared_mode_out;
      st_d.pad_q.oe[mfps_pkg::PAD_DENSITY] = 1'b1;
    end else begin
      st_d.pad_q.o[mfps_pkg::PAD_DENSITY] = fout.drive_density_sel_1;
      st_d.pad_q.oe[mfps_pkg::PAD_DENSITY] = 1'b1;
    end

    // Pci clock and serial irq pins
    if (par_irq) begin
      st_d.pad_q.o[mfps_pkg::PAD_PCI_CLK] = irq_o[mfps_pkg::IRQ4];
      st_d.pad_q.oe[mfps_pkg::PAD_PCI_CLK] = irq_oe[mfps_pkg::IRQ4];
      st_d.pad_q.o[mfps_pkg::PAD_SER_IRQ] = irq_o[mfps_pkg::IRQ3];
      st_d.pad_q.oe[mfps_pkg::PAD_SER_IRQ] = irq_oe[mfps_pkg::IRQ3];
    end else begin
      st_d.fin_q.pci_clock_in = s[mfps_pkg::PAD_PCI_CLK];
      st_d.fin_q.ser_irq_i = s[mfps_pkg::PAD_SER_IRQ];
      st_d.pad_q.o[mfps_pkg::PAD_SER_IRQ] = fout.ser_irq_o;
      st_d.pad_q.oe[mfps_pkg::PAD_SER_IRQ] = fout.ser_irq_oe;
    end

    // Dma channel 3 pins
    if (cfg.dma_three_pin_choice) begin
      st_d.pad_q.o[mfps_pkg::PAD_DACK] = fout.kbc_port_bit16;
      st_d.pad_q.oe[mfps_pkg::PAD_DACK] = 1'b1;
      st_d.pad_q.o[mfps_pkg::PAD_DRQ] = fout.kbc_port_bit12;
      st_d.pad_q.oe[mfps_pkg::PAD_DRQ] = 1'b1;
    end else begin
      st_d.fin_q.dma_ch3_ack_n = s[mfps_pkg::PAD_DACK];
      st_d.pad_q.o[mfps_pkg::PAD_DRQ] = fout.dma_ch3_request;
      st_d.pad_q.oe[mfps_pkg::PAD_DRQ] = 1'b1;
    end

    // Ring and carrier pins; keyboard bits win over irqs
    if (cfg.kbc_modem_pin_choice) begin
      st_d.pad_q.o[mfps_pkg::PAD_RI] = fout.kbc_port_bit16;
      st_d.pad_q.oe[mfps_pkg::PAD_RI] = 1'b1;
      st_d.pad_q.o[mfps_pkg::PAD_DCD] = fout.kbc_port_bit12;
      st_d.pad_q.oe[mfps_pkg::PAD_DCD] = 1'b1;
    end else if (par_irq) begin
      st_d.pad_q.o[mfps_pkg::PAD_RI] = irq_o[mfps_pkg::IRQ12];
      st_d.pad_q.oe[mfps_pkg::PAD_RI] = irq_oe[mfps_pkg::IRQ12];
      st_d.pad_q.o[mfps_pkg::PAD_DCD] = irq_o[mfps_pkg::IRQ11];
      st_d.pad_q.oe[mfps_pkg::PAD_DCD] = irq_oe[mfps_pkg::IRQ11];
    end else begin
      st_d.fin_q.uart2_ring_ind_n = s[mfps_pkg::PAD_RI];
      st_d.fin_q.uart2_carrier_det_n = s[mfps_pkg::PAD_DCD];
    end

    // Uart2 data pins
    if (cfg.ir_option_choice) begin
      st_d.fin_q.infrared_receive = s[mfps_pkg::PAD_RXD];
      st_d.pad_q.o[mfps_pkg::PAD_TXD] = fout.infrared_transmit;
    end else begin
      st_d.fin_q.uart2_receive_line = s[mfps_pkg::PAD_RXD];
      st_d.pad_q.o[mfps_pkg::PAD_TXD] = fout.uart2_transmit_line;
    end
    st_d.pad_q.oe[mfps_pkg::PAD_TXD] = 1'b1;

    // Remaining modem pins; address mode wins over irqs
    if (addr_mode) begin
      st_d.fin_q.host_addr_bit_15 = s[mfps_pkg::PAD_DSR];
      st_d.fin_q.host_addr_bit_12 = s[mfps_pkg::PAD_RTS];
      st_d.fin_q.host_addr_bit_13 = s[mfps_pkg::PAD_CTS];
      st_d.fin_q.host_addr_bit_14 = s[mfps_pkg::PAD_DTR];
      st_d.fin_q.host_addr_bit_11 = st_q.cs_sync_q;
    end else if (par_irq) begin
      st_d.pad_q.o[mfps_pkg::PAD_DSR] = irq_o[mfps_pkg::IRQ10];
      st_d.pad_q.oe[mfps_pkg::PAD_DSR] = irq_oe[mfps_pkg::IRQ10];
      st_d.pad_q.o[mfps_pkg::PAD_RTS] = irq_o[mfps_pkg::IRQ5];
      st_d.pad_q.oe[mfps_pkg::PAD_RTS] = irq_oe[mfps_pkg::IRQ5];
      st_d.pad_q.o[mfps_pkg::PAD_CTS] = irq_o[mfps_pkg::IRQ6];
      st_d.pad_q.oe[mfps_pkg::PAD_CTS] = irq_oe[mfps_pkg::IRQ6];
      st_d.pad_q.o[mfps_pkg::PAD_DTR] = irq_o[mfps_pkg::IRQ7];
      st_d.pad_q.oe[mfps_pkg::PAD_DTR] = irq_oe[mfps_pkg::IRQ7];
    end else begin
      st_d.fin_q.uart2_set_ready_n = s[mfps_pkg::PAD_DSR];
      st_d.fin_q.uart2_clear_send_n = s[mfps_pkg::PAD_CTS];
      st_d.pad_q.o[mfps_pkg::PAD_RTS] = fout.uart2_req_send_n;
      st_d.pad_q.oe[mfps_pkg::PAD_RTS] = 1'b1;
      st_d.pad_q.o[mfps_pkg::PAD_DTR] = fout.uart2_term_ready_n;
      st_d.pad_q.oe[mfps_pkg::PAD_DTR] = 1'b1;
    end

    // Reset: pads quiet, function inputs cleared
    if (reset) begin
      st_d.pad_q = '0;
      st_d.fin_q = '0;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  // Reset is folded into the next state, so synchronisers keep the pad levels
  // and no false active-low input follows the release
  always_ff @(posedge core_clk) begin
    st_q <= st_d;
  end

  // Outputs straight from flops
  assign pad = st_q.pad_q;
  assign fin = st_q.fin_q;
  assign prdata = rsp.prdata;
  assign pready = rsp.pready;
  assign pslverr = rsp.pslverr;

endmodule

/* verification/mfps_monitor.sv */
// Concurrent checks on the pin select top ports
`timescale 1ns/1ns
module mfps_monitor (
  input wire logic core_clk, // Core clock
  input wire logic reset, // Sync reset
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic [7:0] par_irq_req, // Irq requests
  input wire mfps_pkg::mfps_pad_s pad, // Pad drive
  input wire mfps_pkg::mfps_fout_s fout // Function outputs
);
  // ****************
  // Config mirror
  // ****************
  logic [4:0] pc_q; // Pin choice bits
  logic ir_q; // Infrared option
  logic sh_q; // Shared irq mode
  logic wr; // Write lands this edge
  logic bad; // Outside the map
  assign wr = psel && penable && pready && pwrite && !pslverr;
  assign bad = paddr > 8'h10 || paddr[1:0] != 2'h0;
  // Follow software writes on the slave's own edge
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pc_q <= 5'h0;
      ir_q <= 1'b0;
      sh_q <= 1'b0;
    end else if (wr) begin
      if (paddr == mfps_pkg::PIN_CHOICE_OFS) pc_q <= pwdata[4:0];
      if (paddr == mfps_pkg::IR_OPTION_OFS) ir_q <= pwdata[mfps_pkg::IR_OPT_BIT];
      if (paddr == mfps_pkg::PAR_IRQ_OFS) sh_q <= pwdata[mfps_pkg::PAR_SHARED_BIT];
    end
  end
  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  a_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("ready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready too long");
  a_bad_addr: assert property (psel && penable && !pready && bad |=> pslverr && prdata == 32'h0)
    else $error("unmapped not refused");
  a_reset_idle: assert property (
    $fell(reset) |-> pad.oe == 13'h0 ##1 (pad.oe & 13'h1511) == 13'h1511)
    else $error("pads not original after reset");
  a_txd_route: assert property (
    !$past(reset) |-> pad.oe[8] && pad.o[8] == ($past(ir_q) ?
    $past(fout.infrared_transmit) : $past(fout.uart2_transmit_line)))
    else $error("transmit pad wrong");
  a_density_route: assert property (
    !$past(reset) |-> pad.oe[0] == !$past(pc_q[4]) && (!pad.oe[0] || pad.o[0] ==
    ($past(pc_q[0]) ? $past(fout.infrared_mode_out) : $past(fout.drive_density_sel_1))))
    else $error("density pad wrong");
  a_dma_route: assert property (
    !$past(reset) |-> pad.oe[4] && pad.oe[3] == $past(pc_q[1]) && pad.o[4] ==
    ($past(pc_q[1]) ? $past(fout.kbc_port_bit12) : $past(fout.dma_ch3_request)))
    else $error("dma pads wrong");
  a_irq_pulse: assert property (
    sh_q && pc_q[2] && $rose(par_irq_req[0]) |->
    ##[1:2] (pad.oe[2] && !pad.o[2]) [*5] ##1 !pad.oe[2])
    else $error("shared irq pulse wrong");
endmodule
bind mfps_top mfps_monitor mfps_monitor_i (.core_clk(core_clk), .reset(reset), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .par_irq_req(par_irq_req), .pad(pad), .fout(fout));

/* verification/mfps_board.sv */
// Board side of the shared pads: pull-ups and outside drivers
`timescale 1ns/1ns
module mfps_board (
  input wire mfps_pkg::mfps_pad_s pad, // Chip pad drive
  input wire logic [12:0] drv, // Board level on undriven pads
  output logic [12:0] pad_i // Resolved pad levels
);
  // A driven pad shows the chip level, else the board or pull-up
  assign pad_i = (pad.oe & pad.o) | (~pad.oe & drv);
endmodule

/* verification/multifunction_pin_select_tb.sv */
// Self-checking bench for the multifunction pin select block
`timescale 1ns/1ns
module multifunction_pin_select_tb;
  // ****************
  // Wiring
  // ****************
  logic core_clk, reset, psel, penable, pwrite, chip_select_n; // Controls
  logic pready, pslverr; // Bus answer
  logic [7:0] paddr, par_irq_req; // Address, irq requests
  logic [31:0] pwdata, prdata; // Bus data
  logic [12:0] pad_i, drv; // Pad levels, board drive
  mfps_pkg::mfps_pad_s pad; // Pad drive
  mfps_pkg::mfps_fout_s fout; // Function outputs
  mfps_pkg::mfps_fin_s fin; // Function inputs
  int miscompares, comparisons, cycles; // Counters
  mfps_top mfps_top_i (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pad_i(pad_i), .pad(pad), .chip_select_n(chip_select_n),
    .par_irq_req(par_irq_req), .fout(fout), .fin(fin));
  mfps_board mfps_board_i (.pad(pad), .drv(drv), .pad_i(pad_i));
  // 50 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // ****************
  // Tasks
  // ****************
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic results();
    if (miscompares == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // One APB transfer, answer judged at the ready edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [31:0] ed, input logic ee);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    chk(prdata, ed);
    chk(32'(pslverr), 32'(ee));
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic s_reset();
    reset <= 1'b1;
    tick(5);
    reset <= 1'b0;
    tick(3);
    chk(32'(pad.oe), 32'h1511);
    chk(32'({fin.pci_clock_in, fin.ser_irq_i}), 32'h3);
    chk(32'({fin.dma_ch3_ack_n, fin.uart2_ring_ind_n}), 32'h3);
    chk(32'({fin.uart2_carrier_det_n, fin.uart2_set_ready_n}), 32'h3);
    chk(32'(fin.uart2_clear_send_n), 32'h1);
    apb(1'b0, 8'h00, 32'h0, 32'h0, 1'b0);
    apb(1'b0, 8'h10, 32'h0, 32'h15110AEE, 1'b0);
  endtask
  task automatic s_regs();
    logic [7:0] ofs [4] = '{8'h00, 8'h04, 8'h08, 8'h0C};
    logic [31:0] msk [4] = '{32'h1F, 32'h40, 32'h40, 32'h1};
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, ofs[i], 32'hFFFFFFFF, 32'h0, 1'b0);
      apb(1'b0, ofs[i], 32'h0, msk[i], 1'b0);
      apb(1'b1, ofs[i], 32'h0, 32'h0, 1'b0);
    end
    apb(1'b1, 8'h14, 32'h1, 32'h0, 1'b1);
    apb(1'b0, 8'h14, 32'h0, 32'h0, 1'b1);
    apb(1'b1, 8'h10, 32'h1, 32'h0, 1'b1);
  endtask
  task automatic s_ir();
    apb(1'b1, 8'h04, 32'h40, 32'h0, 1'b0);
    drv[7] <= 1'b0;
    fout.infrared_transmit <= 1'b1;
    tick(5);
    chk(32'({fin.infrared_receive, fin.uart2_receive_line, pad.o[8]}), 32'h3);
    drv[7] <= 1'b1;
    tick(5);
    chk(32'(fin.infrared_receive), 32'h1);
    apb(1'b1, 8'h04, 32'h0, 32'h0, 1'b0);
  endtask
  task automatic s_irq();
    apb(1'b1, 8'h00, 32'h4, 32'h0, 1'b0);
    par_irq_req <= 8'h02;
    tick(4);
    chk(32'(pad.oe & 13'h1E66), 32'h1E66);
    chk(32'(pad.o & 13'h1E66), 32'h2);
    par_irq_req <= 8'h00;
    apb(1'b1, 8'h0C, 32'h1, 32'h0, 1'b0);
    par_irq_req <= 8'h01;
    tick(4);
    chk(32'({pad.oe[2], pad.o[2]}), 32'h2);
    tick(6);
    chk(32'(pad.oe[2]), 32'h0);
    par_irq_req <= 8'h00;
    apb(1'b1, 8'h0C, 32'h0, 32'h0, 1'b0);
  endtask
  task automatic s_addr();
    apb(1'b1, 8'h08, 32'h40, 32'h0, 1'b0);
    tick(5);
    chk(32'({fin.host_addr_bit_11, fin.host_addr_bit_12, pad.oe[10]}), 32'h6);
    chip_select_n <= 1'b0;
    drv[10] <= 1'b0;
    tick(5);
    chk(32'({fin.host_addr_bit_11, fin.host_addr_bit_12}), 32'h0);
    apb(1'b1, 8'h08, 32'h0, 32'h0, 1'b0);
  endtask
  task automatic s_kbc();
    apb(1'b1, 8'h00, 32'h1A, 32'h0, 1'b0);
    fout.kbc_port_bit16 <= 1'b1;
    tick(5);
    chk(32'({pad.oe[3], pad.o[3], pad.oe[5], pad.o[5], pad.oe[6]}), 32'h1F);
    chk(32'({pad.o[6], pad.oe[0], fin.infrared_receive_third}), 32'h1);
    apb(1'b1, 8'h00, 32'h1, 32'h0, 1'b0);
    fout.infrared_mode_out <= 1'b1;
    tick(3);
    chk(32'({pad.oe[0], pad.o[0]}), 32'h3);
  endtask
  // Main sequence, ends with a mid-run reset
  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    chip_select_n = 1'b1;
    par_irq_req = 8'h00;
    fout = '0;
    drv = 13'h1FFF;
    miscompares = 0;
    comparisons = 0;
    s_reset();
    s_regs();
    s_ir();
    s_irq();
    s_addr();
    s_kbc();
    s_reset();
    results();
  end
  // Hang guard
  initial begin
    cycles = 0;
    forever begin
      @(posedge core_clk);
      cycles++;
      if (cycles == 3000) begin
        miscompares++;
        results();
      end
    end
  end
endmodule
